// ---- pocc_ctrl.sv ----
// protocol operation control: command filter, deferred requests, halting
`timescale 1ns/10ps
`default_nettype none
module pocc_ctrl #(
    parameter int CNT_W = pocc_pkg::DEG_CNT_W
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire logic cmd_valid_in,
    input wire logic [pocc_pkg::CMD_W-1:0] cmd_in,
    input wire pocc_pkg::pocc_event_s evt_in,
    input wire logic self_test_err_in,
    input wire logic sync_err_in,
    input wire logic severe_err_in,
    input wire logic [CNT_W-1:0] passive_limit_in,
    input wire logic [CNT_W-1:0] halt_limit_in,
    input wire logic [CNT_W-1:0] recover_limit_in,
    output pocc_pkg::pocc_status_s status_out,
    output logic [3:0] poc_state_out,
    output logic tx_enable_out,
    output logic rx_enable_out,
    output logic core_start_out,
    output logic core_stop_out,
    output logic mode_change_out
);
    pocc_pkg::pocc_state_e st_q, st_d;
    pocc_pkg::pocc_cmd_e cmd;
    pocc_pkg::pocc_event_s ev;
    logic st_sync_q;
    logic halt_req_q, ready_req_q, freeze_q, cs_allow_q;
    logic [1:0] slot_q;
    logic running_q;
    logic to_passive, to_active, to_halt;
    logic is_cfg, defer_cyc, defer_wake, release_def;
    logic is_wake, in_normal;
    logic acc_allow_cs, acc_clear, acc_imm_ready, acc_def_imm;
    logic acc_dhalt_imm, fatal;
    logic do_ready, do_halt;

    // only the asynchronous self-test line is synchronised
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_sync_q <= 1'b0;
            ev <= '0;
        end else if (clk_en_in) begin
            st_sync_q <= self_test_err_in;
            ev <= evt_in;
            ev.self_test_err <= st_sync_q;
        end
    end

    assign cmd = cmd_valid_in ? pocc_pkg::pocc_cmd_e'(cmd_in)
                              : pocc_pkg::CMD_NONE;
    assign is_cfg = (st_q == pocc_pkg::ST_DEFAULT_CONFIG) ||
                    (st_q == pocc_pkg::ST_CONFIG);
    assign is_wake = (st_q == pocc_pkg::ST_WAKE_LISTEN) ||
                     (st_q == pocc_pkg::ST_WAKE_SEND) ||
                     (st_q == pocc_pkg::ST_WAKE_DETECT);
    assign in_normal = (st_q == pocc_pkg::ST_NORMAL_ACTIVE) ||
                       (st_q == pocc_pkg::ST_NORMAL_PASSIVE);
    assign defer_cyc = in_normal || (st_q == pocc_pkg::ST_CS_COLLISION) ||
                       (st_q == pocc_pkg::ST_CS_CONSIST) ||
                       (st_q == pocc_pkg::ST_CS_JOIN);
    assign defer_wake = (st_q == pocc_pkg::ST_WAKE_SEND);
    assign acc_allow_cs = !is_cfg && !is_wake &&
                          (st_q != pocc_pkg::ST_HALT);
    assign acc_clear = !is_cfg && (st_q != pocc_pkg::ST_READY) &&
                       (st_q != pocc_pkg::ST_HALT);
    assign acc_imm_ready = acc_clear;
    assign acc_def_imm = acc_clear && !defer_cyc && !defer_wake;
    assign acc_dhalt_imm = (st_q != pocc_pkg::ST_HALT) && !defer_cyc &&
                           !defer_wake;
    assign fatal = ev.self_test_err || ev.fatal_fsp ||
                   (cmd == pocc_pkg::CMD_FREEZE);

    always_comb begin
        release_def = 1'b0;
        if (defer_cyc && ev.cycle_end) begin
            release_def = 1'b1;
        end
        if (defer_wake && (ev.wake_pattern_done || ev.wake_collision)) begin
            release_def = 1'b1;
        end
        if (st_q == pocc_pkg::ST_CS_COLLISION && ev.header_or_cas) begin
            release_def = 1'b1;
        end
    end

    // a request arriving with its release still executes
    assign do_halt = (cmd == pocc_pkg::CMD_DEFERRED_HALT && acc_dhalt_imm) ||
                     (release_def && (halt_req_q ||
                     (cmd == pocc_pkg::CMD_DEFERRED_HALT &&
                      (defer_cyc || defer_wake))));
    assign do_ready = (cmd == pocc_pkg::CMD_IMMEDIATE_READY && acc_imm_ready) ||
                      (cmd == pocc_pkg::CMD_DEFERRED_READY && acc_def_imm) ||
                      (release_def && (ready_req_q ||
                      (cmd == pocc_pkg::CMD_DEFERRED_READY &&
                       (defer_cyc || defer_wake))));

    pocc_degrade #(
        .CNT_W(CNT_W)
    ) u_degrade (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .clk_en_in(clk_en_in),
        .enable_in(in_normal),
        .passive_in(st_q == pocc_pkg::ST_NORMAL_PASSIVE),
        .cycle_end_in(ev.cycle_end),
        .sync_err_in(sync_err_in),
        .severe_err_in(severe_err_in),
        .passive_limit_in(passive_limit_in),
        .halt_limit_in(halt_limit_in),
        .recover_limit_in(recover_limit_in),
        .to_passive_out(to_passive),
        .to_active_out(to_active),
        .to_halt_out(to_halt)
    );

    // next state; unlisted commands fall through unchanged
    always_comb begin
        st_d = st_q;
        if (fatal) begin
            st_d = pocc_pkg::ST_HALT;
        end else if (do_halt || (in_normal && to_halt)) begin
            st_d = pocc_pkg::ST_HALT;
        end else if (do_ready) begin
            st_d = pocc_pkg::ST_READY;
        end else begin
            case (st_q)
                pocc_pkg::ST_DEFAULT_CONFIG: begin
                    if (cmd == pocc_pkg::CMD_CONFIG) st_d = pocc_pkg::ST_CONFIG;
                end
                pocc_pkg::ST_CONFIG: begin
                    if (cmd == pocc_pkg::CMD_CONFIG_COMPLETE) begin
                        st_d = pocc_pkg::ST_READY;
                    end
                end
                pocc_pkg::ST_READY: begin
                    if (cmd == pocc_pkg::CMD_CONFIG) st_d = pocc_pkg::ST_CONFIG;
                    else if (cmd == pocc_pkg::CMD_RUN) begin
                        st_d = pocc_pkg::ST_STARTUP;
                    end else if (cmd == pocc_pkg::CMD_WAKEUP) begin
                        st_d = pocc_pkg::ST_WAKE_LISTEN;
                    end
                end
                pocc_pkg::ST_HALT: begin
                    if (cmd == pocc_pkg::CMD_DEFAULT_CONFIG) begin
                        st_d = pocc_pkg::ST_DEFAULT_CONFIG;
                    end
                end
                pocc_pkg::ST_WAKE_LISTEN, pocc_pkg::ST_WAKE_SEND,
                pocc_pkg::ST_WAKE_DETECT: begin
                    if (ev.wake_done) st_d = pocc_pkg::ST_READY;
                end
                pocc_pkg::ST_STARTUP, pocc_pkg::ST_CS_COLLISION,
                pocc_pkg::ST_CS_CONSIST, pocc_pkg::ST_CS_JOIN: begin
                    if (ev.startup_done) st_d = pocc_pkg::ST_NORMAL_ACTIVE;
                end
                pocc_pkg::ST_NORMAL_ACTIVE: begin
                    if (to_passive) st_d = pocc_pkg::ST_NORMAL_PASSIVE;
                end
                pocc_pkg::ST_NORMAL_PASSIVE: begin
                    if (to_active) st_d = pocc_pkg::ST_NORMAL_ACTIVE;
                end
                default: st_d = pocc_pkg::ST_HALT;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q <= pocc_pkg::pocc_state_e'(pocc_pkg::RST_POC_STATE);
        end else if (clk_en_in) begin
            st_q <= st_d;
        end
    end

    // pending deferred requests; a new request wins over clear-deferred
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            halt_req_q <= pocc_pkg::RST_FLAG;
            ready_req_q <= pocc_pkg::RST_FLAG;
        end else if (clk_en_in) begin
            if (st_d != st_q || release_def ||
                (cmd == pocc_pkg::CMD_CLEAR_DEFERRED && acc_clear)) begin
                halt_req_q <= 1'b0;
                ready_req_q <= 1'b0;
            end
            if (!fatal && !to_halt && !release_def &&
                (defer_cyc || defer_wake)) begin
                if (cmd == pocc_pkg::CMD_DEFERRED_HALT) halt_req_q <= 1'b1;
                if (cmd == pocc_pkg::CMD_DEFERRED_READY) ready_req_q <= 1'b1;
            end
        end
    end

    // freeze flag, slot mode and coldstart permission
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            freeze_q <= pocc_pkg::RST_FLAG;
            slot_q <= pocc_pkg::RST_SLOT;
            cs_allow_q <= pocc_pkg::RST_FLAG;
        end else if (clk_en_in) begin
            if (fatal) freeze_q <= 1'b1;
            else if (st_d == pocc_pkg::ST_DEFAULT_CONFIG) freeze_q <= 1'b0;
            if (st_d == pocc_pkg::ST_READY || st_d == pocc_pkg::ST_HALT ||
                is_cfg) begin
                slot_q <= pocc_pkg::SM_KEYSLOT;
            end else if (cmd == pocc_pkg::CMD_ALL_SLOTS && in_normal) begin
                slot_q <= pocc_pkg::SM_ALL_PENDING;
            end else if (slot_q == pocc_pkg::SM_ALL_PENDING && ev.cycle_end) begin
                slot_q <= pocc_pkg::SM_ALL;
            end
            if (cmd == pocc_pkg::CMD_ALLOW_COLDSTART && acc_allow_cs) begin
                cs_allow_q <= 1'b1;
            end else if (st_d == pocc_pkg::ST_READY ||
                         st_d == pocc_pkg::ST_HALT) begin
                cs_allow_q <= 1'b0;
            end
        end
    end

    function automatic logic [2:0] report(input pocc_pkg::pocc_state_e s);
        case (s)
            pocc_pkg::ST_DEFAULT_CONFIG: report = pocc_pkg::RP_DEFAULT_CONFIG;
            pocc_pkg::ST_CONFIG: report = pocc_pkg::RP_CONFIG;
            pocc_pkg::ST_READY: report = pocc_pkg::RP_READY;
            pocc_pkg::ST_HALT: report = pocc_pkg::RP_HALT;
            pocc_pkg::ST_NORMAL_ACTIVE: report = pocc_pkg::RP_NORMAL_ACTIVE;
            pocc_pkg::ST_NORMAL_PASSIVE: report = pocc_pkg::RP_NORMAL_PASSIVE;
            pocc_pkg::ST_WAKE_LISTEN, pocc_pkg::ST_WAKE_SEND,
            pocc_pkg::ST_WAKE_DETECT: report = pocc_pkg::RP_WAKEUP;
            default: report = pocc_pkg::RP_STARTUP;
        endcase
    endfunction : report

    // registered outputs taken from next-state values, except core_start_out, which pulses only in the first enabled cycle after reset
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            poc_state_out <= pocc_pkg::RST_POC_STATE;
            tx_enable_out <= 1'b0;
            rx_enable_out <= 1'b0;
            core_start_out <= 1'b0;
            core_stop_out <= 1'b0;
            mode_change_out <= 1'b0;
            running_q <= 1'b0;
        end else if (clk_en_in) begin
            poc_state_out <= st_d;
            tx_enable_out <= (st_d == pocc_pkg::ST_NORMAL_ACTIVE);
            rx_enable_out <= (st_d == pocc_pkg::ST_NORMAL_ACTIVE) ||
                             (st_d == pocc_pkg::ST_NORMAL_PASSIVE);
            core_start_out <= !running_q;
            running_q <= 1'b1;
            core_stop_out <= (st_d == pocc_pkg::ST_HALT) &&
                             (st_q != pocc_pkg::ST_HALT);
            mode_change_out <= (in_normal || st_q == pocc_pkg::ST_HALT) &&
                               (st_d != st_q);
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_out <= '0;
            status_out.state <= pocc_pkg::RST_STATE;
        end else if (clk_en_in) begin
            status_out.state <= report(st_d);
            status_out.freeze <= freeze_q;
            status_out.halt_req <= halt_req_q;
            status_out.ready_req <= ready_req_q;
            status_out.slot_mode <= slot_q;
            status_out.coldstart_allowed <= cs_allow_q;
        end
    end

    property p_freeze_halts;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && cmd_valid_in && cmd_in == pocc_pkg::CMD_FREEZE)
        |=> st_q == pocc_pkg::ST_HALT;
    endproperty
    a_freeze_halts: assert property (p_freeze_halts)
        else $error("freeze did not halt");

    property p_run_only_ready;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && st_q != pocc_pkg::ST_STARTUP && st_d == pocc_pkg::ST_STARTUP)
        |-> st_q == pocc_pkg::ST_READY;
    endproperty
    a_run_only_ready: assert property (p_run_only_ready)
        else $error("startup entered from a non-ready state");

    property p_tx_passive;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && st_d == pocc_pkg::ST_NORMAL_PASSIVE)
        |=> !tx_enable_out && rx_enable_out;
    endproperty
    a_tx_passive: assert property (p_tx_passive)
        else $error("transmission in passive state");

    property p_defer_hold;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && defer_cyc && !release_def && !fatal && !to_halt &&
         cmd == pocc_pkg::CMD_DEFERRED_HALT)
        |=> halt_req_q && st_q != pocc_pkg::ST_HALT;
    endproperty
    a_defer_hold: assert property (p_defer_hold)
        else $error("deferred halt not held");

    property p_freeze_flag;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && fatal) |=> ##1 status_out.freeze;
    endproperty
    a_freeze_flag: assert property (p_freeze_flag)
        else $error("freeze flag not reported");

    property p_default_cfg;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && st_d == pocc_pkg::ST_DEFAULT_CONFIG &&
         st_q != pocc_pkg::ST_DEFAULT_CONFIG) |-> st_q == pocc_pkg::ST_HALT;
    endproperty
    a_default_cfg: assert property (p_default_cfg)
        else $error("default config entered from wrong state");

    property p_stop_on_halt;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && st_d == pocc_pkg::ST_HALT && st_q != pocc_pkg::ST_HALT)
        |=> core_stop_out;
    endproperty
    a_stop_on_halt: assert property (p_stop_on_halt)
        else $error("core not stopped on halt");

    property p_config_cmd;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && st_d == pocc_pkg::ST_CONFIG && st_q != pocc_pkg::ST_CONFIG)
        |-> cmd == pocc_pkg::CMD_CONFIG;
    endproperty
    a_config_cmd: assert property (p_config_cmd)
        else $error("config entered without command");
endmodule : pocc_ctrl
`default_nettype wire

// ---- pocc_pkg.sv ----
// package for the protocol operation control command block
package pocc_pkg;
    localparam int CMD_W = 4;
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0, CMD_ALL_SLOTS = 4'h1, CMD_ALLOW_COLDSTART = 4'h2,
        CMD_CLEAR_DEFERRED = 4'h3, CMD_CONFIG = 4'h4,
        CMD_CONFIG_COMPLETE = 4'h5, CMD_DEFAULT_CONFIG = 4'h6,
        CMD_RUN = 4'h7, CMD_WAKEUP = 4'h8, CMD_FREEZE = 4'h9,
        CMD_IMMEDIATE_READY = 4'ha, CMD_DEFERRED_READY = 4'hb,
        CMD_DEFERRED_HALT = 4'hc
    } pocc_cmd_e;
    // detailed control state
    typedef enum logic [3:0] {
        ST_DEFAULT_CONFIG = 4'h0, ST_CONFIG = 4'h1, ST_READY = 4'h2,
        ST_HALT = 4'h3, ST_WAKE_LISTEN = 4'h4, ST_WAKE_SEND = 4'h5,
        ST_WAKE_DETECT = 4'h6, ST_STARTUP = 4'h7, ST_CS_COLLISION = 4'h8,
        ST_CS_CONSIST = 4'h9, ST_CS_JOIN = 4'ha, ST_NORMAL_ACTIVE = 4'hb,
        ST_NORMAL_PASSIVE = 4'hc
    } pocc_state_e;
    // reported state encoding
    typedef enum logic [2:0] {
        RP_CONFIG = 3'h0, RP_DEFAULT_CONFIG = 3'h1, RP_HALT = 3'h2,
        RP_NORMAL_ACTIVE = 3'h3, RP_NORMAL_PASSIVE = 3'h4, RP_READY = 3'h5,
        RP_STARTUP = 3'h6, RP_WAKEUP = 3'h7
    } pocc_rstate_e;
    typedef enum logic [1:0] {
        SM_KEYSLOT = 2'h0, SM_ALL_PENDING = 2'h1, SM_ALL = 2'h2
    } pocc_slot_e;
    typedef struct packed {
        logic [2:0] state;
        logic freeze;
        logic halt_req;
        logic ready_req;
        logic [1:0] slot_mode;
        logic coldstart_allowed;
    } pocc_status_s;
    // protocol events from the core mechanisms
    typedef struct packed {
        logic cycle_end;
        logic wake_pattern_done;
        logic wake_collision;
        logic header_or_cas;
        logic startup_done;
        logic wake_done;
        logic fatal_fsp;
        logic self_test_err;
    } pocc_event_s;
    localparam logic [2:0] RST_STATE = 3'h1;
    localparam logic [1:0] RST_SLOT = 2'h0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic [3:0] RST_POC_STATE = 4'h0;
    localparam int DEG_CNT_W = 4;
endpackage : pocc_pkg

// ---- pocc_degrade.sv ----
// degradation model: active, passive, halt decision from sync errors
`timescale 1ns/10ps
`default_nettype none
module pocc_degrade #(
    parameter int CNT_W = pocc_pkg::DEG_CNT_W
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire logic enable_in,
    input wire logic passive_in,
    input wire logic cycle_end_in,
    input wire logic sync_err_in,
    input wire logic severe_err_in,
    input wire logic [CNT_W-1:0] passive_limit_in,
    input wire logic [CNT_W-1:0] halt_limit_in,
    input wire logic [CNT_W-1:0] recover_limit_in,
    output logic to_passive_out,
    output logic to_active_out,
    output logic to_halt_out
);
    logic [CNT_W-1:0] err_q;
    logic [CNT_W-1:0] ok_q;
    logic eval;
    assign eval = enable_in && cycle_end_in;

    // error and good-cycle counters, evaluated once per cycle end
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            err_q <= '0;
            ok_q <= '0;
        end else if (clk_en_in) begin
            if (!enable_in) begin
                err_q <= '0;
                ok_q <= '0;
            end else if (eval && sync_err_in) begin
                err_q <= (err_q == '1) ? err_q : err_q + 1'b1;
                ok_q <= '0;
            end else if (eval) begin
                ok_q <= (ok_q == '1) ? ok_q : ok_q + 1'b1;
                if (passive_in && ok_q + 1'b1 >= recover_limit_in) begin
                    err_q <= '0;
                end
            end
        end
    end

    // limits are configurable; severe errors halt at once
    always_comb begin
        to_halt_out = 1'b0;
        to_passive_out = 1'b0;
        to_active_out = 1'b0;
        if (enable_in && severe_err_in) begin
            to_halt_out = 1'b1;
        end else if (eval && sync_err_in) begin
            if (passive_in && err_q + 1'b1 >= halt_limit_in) begin
                to_halt_out = 1'b1;
            end else if (!passive_in && err_q + 1'b1 >= passive_limit_in) begin
                to_passive_out = 1'b1;
            end
        end else if (eval && passive_in && ok_q + 1'b1 >= recover_limit_in) begin
            to_active_out = 1'b1;
        end
    end
endmodule : pocc_degrade
`default_nettype wire

// ---- pocc_host_model.sv ----
// host side model: relays each command as a single-cycle request pulse
`timescale 1ns/10ps
`default_nettype none
module pocc_host_model (
    input wire logic ref_clk_in,
    input wire logic go_in,
    input wire logic [3:0] code_in,
    output logic cmd_valid_out,
    output logic [3:0] cmd_out
);
    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = 4'h0;
    end
    // idle code toggles so a stale command value is never mistaken for data
    always @(posedge ref_clk_in) begin
        cmd_valid_out <= go_in;
        cmd_out <= go_in ? code_in : ~cmd_out;
    end
endmodule : pocc_host_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the operation control command block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %0t got %h want %h", $time, g, e); end checks_done++;
module testbench;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic go = 1'b0, probe = 1'b0, cmd_valid;
    logic [3:0] code = 4'h0, cmd, poc_state;
    logic [3:0] lim_p = 4'h2, lim_h = 4'h2, lim_r = 4'h2;
    logic tx_en, rx_en, c_start, c_stop, m_chg;
    pocc_pkg::pocc_event_s evt = '0;
    pocc_pkg::pocc_status_s st;
    logic [9:0] expq[$];
    logic [9:0] exp_v;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    logic st_err = 1'b0, s_err = 1'b0, sv_err = 1'b0;
    int n_start = 0, n_stop = 0, n_chg = 0;
    // detailed state expected for each reported state code
    logic [3:0] det[8] = '{4'h1, 4'h0, 4'h3, 4'hb, 4'hc, 4'h2, 4'h7, 4'h4};
    always #10 ref_clk_in = ~ref_clk_in;
    pocc_host_model host_u (.ref_clk_in(ref_clk_in), .go_in(go),
        .code_in(code), .cmd_valid_out(cmd_valid), .cmd_out(cmd));
    pocc_ctrl dut_u (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
        .clk_en_in(1'b1), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
        .evt_in(evt), .self_test_err_in(st_err), .sync_err_in(s_err),
        .severe_err_in(sv_err), .passive_limit_in(lim_p),
        .halt_limit_in(lim_h), .recover_limit_in(lim_r),
        .status_out(st), .poc_state_out(poc_state), .tx_enable_out(tx_en),
        .rx_enable_out(rx_en), .core_start_out(c_start),
        .core_stop_out(c_stop), .mode_change_out(m_chg));
    // monitor: oldest note against the observed status
    always @(posedge ref_clk_in) begin
        if (probe) begin
            exp_v = expq.pop_front();
            `CHK({st.state, st.freeze, st.halt_req, tx_en, st.ready_req, st.slot_mode, st.coldstart_allowed}, exp_v)
            `CHK(rx_en, exp_v[9:7] == 3'h3 || exp_v[9:7] == 3'h4)
            `CHK(poc_state, det[exp_v[9:7]])
        end
    end
    always @(posedge ref_clk_in) begin
        cyc++;
        if (c_start === 1'b1) n_start++;
        if (c_stop === 1'b1) n_stop++;
        if (m_chg === 1'b1) n_chg++;
        if (cyc == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic note(input logic [2:0] s, input logic f, h, t,
                        input logic [3:0] x = 4'h0);
        repeat (3) @(posedge ref_clk_in);
        expq.push_back({s, f, h, t, x});
        probe <= 1'b1;
        @(posedge ref_clk_in);
        probe <= 1'b0;
    endtask : note
    task automatic send(input logic [3:0] c, input logic [2:0] s,
                        input logic f, h, t, input logic [3:0] x = 4'h0);
        @(posedge ref_clk_in);
        go <= 1'b1;
        code <= c;
        @(posedge ref_clk_in);
        go <= 1'b0;
        note(s, f, h, t, x);
    endtask : send
    task automatic event_pulse(input bit cyc_end);
        @(posedge ref_clk_in);
        if (cyc_end) evt.cycle_end <= 1'b1;
        else evt.startup_done <= 1'b1;
        @(posedge ref_clk_in);
        evt <= '0;
    endtask : event_pulse
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    logic [3:0] bad[9] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8,
                           4'ha, 4'hb};
    initial begin
        void'($urandom(96276));
        lim_p <= 4'($urandom_range(1, 15));
        lim_h <= 4'($urandom_range(1, 15));
        lim_r <= 4'($urandom_range(1, 15));
        repeat (16) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        note(3'h1, 1'b0, 1'b0, 1'b0);
        $display("reset state checked");
        // commands not accepted in default config leave no trace
        for (int i = 0; i < 12; i++) begin
            send(bad[$urandom_range(0, 8)], 3'h1, 1'b0, 1'b0, 1'b0);
        end
        $display("ignored commands checked");
        send(4'h4, 3'h0, 1'b0, 1'b0, 1'b0);
        send(4'h7, 3'h0, 1'b0, 1'b0, 1'b0);
        send(4'h5, 3'h5, 1'b0, 1'b0, 1'b0);
        send(4'h3, 3'h5, 1'b0, 1'b0, 1'b0);
        send(4'h7, 3'h6, 1'b0, 1'b0, 1'b0);
        send(4'ha, 3'h5, 1'b0, 1'b0, 1'b0);
        send(4'h8, 3'h7, 1'b0, 1'b0, 1'b0);
        send(4'h9, 3'h2, 1'b1, 1'b0, 1'b0);
        send(4'h4, 3'h2, 1'b1, 1'b0, 1'b0);
        send(4'h6, 3'h1, 1'b0, 1'b0, 1'b0);
        $display("immediate commands checked");
        send(4'h4, 3'h0, 1'b0, 1'b0, 1'b0);
        send(4'h5, 3'h5, 1'b0, 1'b0, 1'b0);
        send(4'h7, 3'h6, 1'b0, 1'b0, 1'b0);
        event_pulse(1'b0);
        note(3'h3, 1'b0, 1'b0, 1'b1);
        send(4'hc, 3'h3, 1'b0, 1'b1, 1'b1);
        event_pulse(1'b1);
        note(3'h2, 1'b0, 1'b0, 1'b0);
        $display("deferred halt checked");
        send(4'h6, 3'h1, 1'b0, 1'b0, 1'b0);
        send(4'h4, 3'h0, 1'b0, 1'b0, 1'b0);
        send(4'h5, 3'h5, 1'b0, 1'b0, 1'b0);
        send(4'h7, 3'h6, 1'b0, 1'b0, 1'b0);
        send(4'h2, 3'h6, 1'b0, 1'b0, 1'b0, 4'h1);
        event_pulse(1'b0);
        note(3'h3, 1'b0, 1'b0, 1'b1, 4'h1);
        send(4'h1, 3'h3, 1'b0, 1'b0, 1'b1, 4'h3);
        event_pulse(1'b1);
        note(3'h3, 1'b0, 1'b0, 1'b1, 4'h5);
        send(4'hb, 3'h3, 1'b0, 1'b0, 1'b1, 4'hd);
        send(4'h3, 3'h3, 1'b0, 1'b0, 1'b1, 4'h5);
        send(4'hb, 3'h3, 1'b0, 1'b0, 1'b1, 4'hd);
        event_pulse(1'b1);
        note(3'h5, 1'b0, 1'b0, 1'b0);
        $display("slot mode and deferred ready checked");
        // fixed limits so the degradation steps can be counted out
        lim_p <= 4'h2;
        lim_h <= 4'h5;
        lim_r <= 4'h2;
        send(4'h7, 3'h6, 1'b0, 1'b0, 1'b0);
        event_pulse(1'b0);
        note(3'h3, 1'b0, 1'b0, 1'b1);
        s_err <= 1'b1;
        event_pulse(1'b1);
        event_pulse(1'b1);
        note(3'h4, 1'b0, 1'b0, 1'b0);
        s_err <= 1'b0;
        event_pulse(1'b1);
        event_pulse(1'b1);
        note(3'h3, 1'b0, 1'b0, 1'b1);
        sv_err <= 1'b1;
        note(3'h2, 1'b0, 1'b0, 1'b0);
        sv_err <= 1'b0;
        $display("degradation checked");
        send(4'h6, 3'h1, 1'b0, 1'b0, 1'b0);
        st_err <= 1'b1;
        // the self-test line crosses two flops before it halts
        @(posedge ref_clk_in);
        note(3'h2, 1'b1, 1'b0, 1'b0);
        st_err <= 1'b0;
        send(4'h6, 3'h1, 1'b0, 1'b0, 1'b0);
        $display("self-test halt checked");
        `CHK(n_start, 1)
        `CHK(n_stop, 4)
        `CHK(n_chg, 9)
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
